/* core/bcg_pin_mux.v */
// Pin function selection for the four port pins.
// Assumes pin order [0]=pin0, [1]=pin3, [2]=pin4, [3]=pin5; strobes are active low.
`timescale 1ns/10ps
`default_nettype none

module bcg_pin_mux (
    input wire expanded,
    input wire pin0_gpio,
    input wire [3:0] dir,
    input wire [3:0] lat,
    input wire write_strobe_n,
    input wire read_strobe_n,
    input wire address_strobe_n,
    output reg [3:0] out,
    output reg [3:0] oe
);

    always @* begin
        out = lat;
        oe = dir;
        if (expanded) begin
            out[3] = write_strobe_n;
            out[2] = read_strobe_n;
            out[1] = address_strobe_n;
            oe[3:1] = 3'b111;
            // With pin0 on the wait input the driver is kept off whatever dir[0] holds, except in soft standby, where pin_oe follows dir.
            oe[0] = pin0_gpio & dir[0];
        end
    end

endmodule // bcg_pin_mux

`default_nettype wire

/* core/bcg_port.v */
// Bus-control GPIO port: direction register, output latch and pin muxing behind AXI4-Lite.
// Assumes strobes come from a bus controller on mclk, pins and standby pin are asynchronous.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "bcg_regs.vh"

module bcg_port #(
    parameter ADDR_WIDTH = 18,
    parameter [2:0] RESET_MODE = `BCG_MODE_SINGLE
) (
    input wire mclk,
    input wire sys_rst,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire write_strobe_n,
    input wire read_strobe_n,
    input wire address_strobe_n,
    output wire bus_wait_n,
    input wire hw_standby_n,
    input wire [3:0] pin_in,
    output reg [3:0] pin_out,
    output reg [3:0] pin_oe
);

    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    reg [7:0] direction_register;
    reg [7:0] output_latch;
    reg [2:0] mode;
    reg soft_standby;
    reg [7:0] wait_enable_bits;
    reg wait_mode_select_bit;
    reg aw_held;
    reg w_held;
    reg [ADDR_WIDTH-1:0] aw_addr;
    reg [7:0] w_byte;
    reg w_lane0;
    wire [3:0] pin_sync;
    wire [1:0] hstby_sync_n;
    wire hw_standby;
    wire expanded;
    wire pin0_gpio;
    wire [3:0] dir4;
    wire [3:0] lat4;
    wire [3:0] mux_out;
    wire [3:0] mux_oe;
    wire do_write;
    wire rd_take;
    wire [7:0] latch_view;
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;

    // ------------------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------------------
    bcg_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // The standby pin goes through the same cell; the other bit is tied high and masks hw_standby until the cell has filled after reset.
    bcg_sync #(
        .WIDTH(2)
    ) u_hstby_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in({1'b1, hw_standby_n}),
        .sync_out(hstby_sync_n)
    );

    assign hw_standby = ~hstby_sync_n[0] & hstby_sync_n[1];

    // ------------------------------------------------------------------------
    // Mode decode.
    // ------------------------------------------------------------------------
    // Mode codes other than 1, 3, 5, 6 behave as the single-chip mode.
    assign expanded = (mode == `BCG_MODE_EXP1) || (mode == `BCG_MODE_EXP3) ||
                      (mode == `BCG_MODE_EXP5) || (mode == `BCG_MODE_EXP6);
    assign pin0_gpio = (wait_enable_bits == `BCG_WAIT_EN_ALL) &&
                       !wait_mode_select_bit;
    assign bus_wait_n = (expanded && !pin0_gpio) ? pin_sync[0] : 1'b1;

    assign dir4 = {direction_register[5:3], direction_register[0]};
    assign lat4 = {output_latch[5:3], output_latch[0]};

    bcg_pin_mux u_mux (
        .expanded(expanded),
        .pin0_gpio(pin0_gpio),
        .dir(dir4),
        .lat(lat4),
        .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n),
        .address_strobe_n(address_strobe_n),
        .out(mux_out),
        .oe(mux_oe)
    );

    // ------------------------------------------------------------------------
    // Pin drivers.
    // ------------------------------------------------------------------------
    // Outputs are registered so the pins never glitch on decode changes.
    always @(posedge mclk) begin
        if (sys_rst || hw_standby) begin
            pin_out <= 4'h0;
            pin_oe <= 4'h0;
        end else if (soft_standby) begin
            pin_out <= pin_out;
            pin_oe <= dir4;
        end else begin
            pin_out <= mux_out;
            pin_oe <= mux_oe;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel.
    // ------------------------------------------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always @(posedge mclk) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {ADDR_WIDTH{1'b0}};
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BCG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map_ok(aw_addr) ? `BCG_RESP_OKAY : `BCG_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function wr_map_ok;
        input [ADDR_WIDTH-1:0] a;
        begin
            wr_map_ok = (a[1:0] == 2'b00) &&
                        ((a[17:2] == `BCG_IDX_DIR) || (a[17:2] == `BCG_IDX_LATCH) ||
                         (a[17:2] == `BCG_IDX_CTRL) || (a[17:2] == `BCG_IDX_WAIT));
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------------
    // Hardware standby clears the port registers just as reset does; the
    // control registers belong to the system and only reset clears them.
    always @(posedge mclk) begin
        if (sys_rst || hw_standby) begin
            direction_register <= `BCG_DIR_RESET;
            output_latch <= `BCG_LATCH_RESET;
        end else if (do_write && w_lane0 && !soft_standby && aw_addr[1:0] == 2'b00) begin
            if (aw_addr[17:2] == `BCG_IDX_DIR) begin
                direction_register <= {1'b1, w_byte[6:0]};
            end
            if (aw_addr[17:2] == `BCG_IDX_LATCH) begin
                output_latch <= {1'b1, w_byte[6:0]};
            end
        end
    end

    // Soft standby itself stays writable so software can leave it again.
    always @(posedge mclk) begin
        if (sys_rst) begin
            mode <= RESET_MODE;
            soft_standby <= 1'b0;
            wait_enable_bits <= `BCG_WAIT_EN_RESET;
        end else if (do_write && w_lane0 && aw_addr[1:0] == 2'b00) begin
            if (aw_addr[17:2] == `BCG_IDX_CTRL) begin
                mode <= w_byte[`BCG_CTRL_MODE_MSB:`BCG_CTRL_MODE_LSB];
                soft_standby <= w_byte[`BCG_CTRL_SSTBY];
            end
            if (aw_addr[17:2] == `BCG_IDX_WAIT) begin
                wait_enable_bits <= w_byte;
            end
        end
    end

    // The wait mode bit sits above the low byte, so it follows byte lane 1.
    reg w_lane1;
    reg w_bit8;
    always @(posedge mclk) begin
        if (sys_rst) begin
            w_lane1 <= 1'b0;
            w_bit8 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_lane1 <= s_axi_wstrb[1];
            w_bit8 <= s_axi_wdata[`BCG_WAIT_MS_BIT];
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            wait_mode_select_bit <= 1'b0;
        end else if (do_write && w_lane1 && aw_addr[1:0] == 2'b00 &&
                     aw_addr[17:2] == `BCG_IDX_WAIT) begin
            wait_mode_select_bit <= w_bit8;
        end
    end

    // ------------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_view
            if (k == `BCG_LATCH_FIXED_BIT) begin : g_fixed
                assign latch_view[k] = 1'b1;
            end else if (k == 6 || k == 2 || k == 1) begin : g_store
                assign latch_view[k] = direction_register[k] ? output_latch[k] : 1'b1;
            end else begin : g_pin
                assign latch_view[k] = direction_register[k] ? output_latch[k] :
                                          pin_sync[(k == 0) ? 0 : k - 2];
            end
        end
    endgenerate

    always @* begin
        next_rdata = 32'h0000_0000;
        next_rresp = `BCG_RESP_OKAY;
        if (s_axi_araddr[1:0] != 2'b00) begin
            next_rresp = `BCG_RESP_SLVERR;
        end else begin
            case (s_axi_araddr[17:2])
                `BCG_IDX_DIR: next_rdata[7:0] = `BCG_DIR_READ;
                `BCG_IDX_LATCH: next_rdata[7:0] = latch_view;
                `BCG_IDX_CTRL: next_rdata[3:0] = {soft_standby, mode};
                `BCG_IDX_WAIT: next_rdata[8:0] = {wait_mode_select_bit, wait_enable_bits};
                `BCG_IDX_STATUS: next_rdata[6:0] = {expanded, hw_standby,
                                                    expanded && !pin0_gpio, pin_sync};
                default: next_rresp = `BCG_RESP_SLVERR;
            endcase
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    always @(posedge mclk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BCG_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // bcg_port

`default_nettype wire

/* core/bcg_regs.vh */
// Constants of the bus-control GPIO port: register indexes, field positions and reset values.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef BCG_REGS_VH
`define BCG_REGS_VH

// ----------------------------------------------------------------------------
// Register indexes; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define BCG_IDX_DIR 16'hffc9
`define BCG_IDX_LATCH 16'hffcb
`define BCG_IDX_CTRL 16'hffc0
`define BCG_IDX_WAIT 16'hffc1
`define BCG_IDX_STATUS 16'hffc2

// ----------------------------------------------------------------------------
// Reset values, the direction read value and the all-enabled wait pattern.
// ----------------------------------------------------------------------------
`define BCG_DIR_RESET 8'h80
`define BCG_LATCH_RESET 8'h80
`define BCG_DIR_READ 8'hff
`define BCG_WAIT_EN_RESET 8'h00
`define BCG_WAIT_EN_ALL 8'hff

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define BCG_CTRL_MODE_LSB 0
`define BCG_CTRL_MODE_MSB 2
`define BCG_CTRL_SSTBY 3
`define BCG_WAIT_MS_BIT 8
`define BCG_LATCH_FIXED_BIT 7
`define BCG_ST_WAIT_SEL 4
`define BCG_ST_HSTBY 5
`define BCG_ST_EXPANDED 6

// ----------------------------------------------------------------------------
// Operating modes and bus responses.
// ----------------------------------------------------------------------------
`define BCG_MODE_EXP1 3'h1
`define BCG_MODE_EXP3 3'h3
`define BCG_MODE_EXP5 3'h5
`define BCG_MODE_EXP6 3'h6
`define BCG_MODE_SINGLE 3'h7
`define BCG_RESP_OKAY 2'h0
`define BCG_RESP_SLVERR 2'h2

`endif

/* core/bcg_sync.v */
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent level; no bus coherence across bits.
`timescale 1ns/10ps
`default_nettype none

module bcg_sync #(
    parameter WIDTH = 4
) (
    input wire mclk,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            always @(posedge mclk) begin
                if (sys_rst) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= async_in[i];
                    stage2 <= stage1;
                end
            end
            assign sync_out[i] = stage2;
        end
    endgenerate

endmodule // bcg_sync

`default_nettype wire

/* test/bcg_pin_model.sv */
// Loads and wait device on the four port pins.
// Assumes the bench chooses which pins the outside drives.
`timescale 1ns/10ps
`default_nettype none
module bcg_pin_model (
    input wire logic mclk,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] ext_oe,
    input wire logic [3:0] ext_val,
    output logic [3:0] pin_in
);
    // No pull-ups here, so a released line toggles instead of keeping its last level.
    logic [3:0] drift = 4'h5;
    always @(posedge mclk) begin
        drift <= ~drift;
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe & drift);
endmodule // bcg_pin_model
`default_nettype wire

/* test/bcg_port_props.sv */
// Checker of the bus-control port: bus answers, pin muxing and standby behaviour.
// Assumes masters offer write address and data together, as the bench does.
`timescale 1ns/10ps
`default_nettype none
`include "bcg_regs.vh"
module bcg_port_props #(
    parameter ADDR_WIDTH = 18
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic address_strobe_n,
    input wire logic bus_wait_n,
    input wire logic hw_standby_n,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe
);
    // ------------------------------------------------------------------
    // Shadow of the control register.
    // ------------------------------------------------------------------
    // The shadow leads the design by one edge, so every window below waits a few cycles.
    logic [2:0] mode;
    logic sstby;
    wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire expd = mode == 3'h1 || mode == 3'h3 || mode == 3'h5 || mode == 3'h6;
    always @(posedge mclk) begin
        if (sys_rst) begin
            mode <= `BCG_MODE_SINGLE;
            sstby <= 1'b0;
        end else if (wr_hs && s_axi_awaddr == {`BCG_IDX_CTRL, 2'b00}) begin
            mode <= s_axi_wdata[2:0];
            sstby <= s_axi_wdata[3];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_exp_run;
        (expd && !sstby && hw_standby_n) [*5];
    endsequence
    sequence s_hw_held;
        (!hw_standby_n) [*6];
    endsequence
    AST_STROBES: assert property (s_exp_run |-> pin_oe[3:1] == 3'b111
        && pin_out[3:1] == {$past(write_strobe_n), $past(read_strobe_n),
        $past(address_strobe_n)}) else $error("strobe pins wrong in expanded mode");
    AST_SINGLE_NO_WAIT: assert property ((!expd) [*3] |-> bus_wait_n)
        else $error("wait asserted in single-chip mode");
    AST_WAIT_PIN0: assert property (!bus_wait_n |=> !pin_oe[0])
        else $error("pin0 driven while it is the wait input");
    AST_SSTBY: assert property ((sstby && hw_standby_n) [*6] |-> $stable(pin_out)
        && $stable(pin_oe)) else $error("pins moved in soft standby");
    AST_HW_STBY: assert property (s_hw_held |-> pin_oe == 4'h0 && pin_out == 4'h0)
        else $error("pins driven in hardware standby");
    AST_BVALID: assert property (wr_hs |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_RVALID: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    AST_NO_AW: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule // bcg_port_props
bind bcg_port bcg_port_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_bcg_port_props (.mclk, .sys_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .write_strobe_n, .read_strobe_n, .address_strobe_n,
    .bus_wait_n, .hw_standby_n, .pin_out, .pin_oe);
`default_nettype wire

/* test/tb_bcg_port.sv */
// Self-checking bench of the bus-control port: register traffic, pin loads, standby.
// Assumes the pin model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "bcg_regs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_bcg_port;
    logic mclk = 1'b0, sys_rst = 1'b1, hw_standby_n = 1'b1;
    logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf, ext_oe = 4'h0, ext_val = 4'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, write_strobe_n = 1, read_strobe_n = 1, address_strobe_n = 1;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_wait_n;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] pin_in, pin_out, pin_oe;
    int error_cnt = 0, checks = 0, seed = 736, i;
    logic [7:0] dir, lat;
    logic [2:0] modes [4] = '{`BCG_MODE_EXP1, `BCG_MODE_EXP3, `BCG_MODE_EXP5, `BCG_MODE_EXP6};
    bcg_port u_bcg_port (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .write_strobe_n, .read_strobe_n,
        .address_strobe_n, .bus_wait_n, .hw_standby_n, .pin_in, .pin_out, .pin_oe);
    bcg_pin_model u_bcg_pin_model (.mclk, .pin_out, .pin_oe, .ext_oe, .ext_val, .pin_in);
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        {write_strobe_n, read_strobe_n, address_strobe_n} <= 3'($random(seed));
    end
    // ------------------------------------------------------------------
    // Bus tasks and expectations.
    // ------------------------------------------------------------------
    task wrap_up;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic axi_wr(input [15:0] idx, input [31:0] d, output [1:0] r);
        int n;
        bit got = 0;
        @(posedge mclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && !got; n++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                got = 1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (!got) begin
            error_cnt++;
            wrap_up();
        end
    endtask
    // Ready is raised one cycle late on purpose, so the slave must hold its data.
    task automatic axi_rd(input [15:0] idx, output [31:0] d, output [1:0] r);
        int n;
        bit got = 0;
        @(posedge mclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50 && !got; n++) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                got = 1;
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end else if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        if (!got) begin
            error_cnt++;
            wrap_up();
        end
    endtask
    function automatic logic [3:0] pins(input logic [7:0] v);
        return {v[5], v[4], v[3], v[0]};
    endfunction
    function automatic logic [7:0] exp_lat(input logic [7:0] d, l, input logic [3:0] p);
        logic [7:0] v;
        v = (d & l) | ~d;
        if (!d[0]) v[0] = p[0];
        if (!d[3]) v[3] = p[1];
        if (!d[4]) v[4] = p[2];
        if (!d[5]) v[5] = p[3];
        v[7] = 1'b1;
        return v;
    endfunction
    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        dir = 8'h80;
        lat = 8'h80;
        ext_oe <= 4'hf;
        ext_val <= 4'($random(seed));
        repeat (3) @(posedge mclk);
        axi_rd(`BCG_IDX_LATCH, d, r);
        `CHK("latch_reset", exp_lat(dir, lat, ext_val), d[7:0])
        for (i = 0; i < 24; i++) begin
            dir = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            lat = 8'($random(seed));
            axi_wr(`BCG_IDX_DIR, {24'h0, dir}, r);
            axi_wr(`BCG_IDX_LATCH, {24'h0, lat}, r);
            ext_oe <= ~pins(dir);
            ext_val <= 4'($random(seed));
            repeat (4) @(posedge mclk);
            `CHK("pin_oe", pins(dir), pin_oe)
            `CHK("pin_out", pins(dir) & pins(lat), pin_out & pin_oe)
            axi_rd(`BCG_IDX_LATCH, d, r);
            `CHK("latch_read", exp_lat(dir, lat, ext_val), d[7:0])
            axi_rd(`BCG_IDX_DIR, d, r);
            `CHK("dir_read", 32'h0000_00ff, d)
        end
        axi_rd(16'hffcc, d, r);
        `CHK("unmapped", `BCG_RESP_SLVERR, r)
        axi_wr(`BCG_IDX_STATUS, 32'h0, r);
        `CHK("status_wr", `BCG_RESP_SLVERR, r)
        axi_wr(`BCG_IDX_CTRL, 32'h0000_000f, r);
        axi_wr(`BCG_IDX_DIR, 32'h0, r);
        axi_wr(`BCG_IDX_LATCH, {24'h0, ~lat}, r);
        repeat (4) @(posedge mclk);
        `CHK("sstby_oe", pins(dir), pin_oe)
        `CHK("sstby_out", pins(dir) & pins(lat), pin_out & pin_oe)
        axi_rd(`BCG_IDX_LATCH, d, r);
        `CHK("sstby_latch", exp_lat(dir, lat, ext_val), d[7:0])
        axi_wr(`BCG_IDX_CTRL, 32'h7, r);
        axi_wr(`BCG_IDX_DIR, 32'h0, r);
        ext_oe <= 4'h1;
        ext_val <= 4'h0;
        for (i = 0; i < 4; i++) begin
            axi_wr(`BCG_IDX_CTRL, {29'h0, modes[i]}, r);
            axi_wr(`BCG_IDX_WAIT, 32'h0, r);
            repeat (4) @(posedge mclk);
            `CHK("strobe_oe", 3'b111, pin_oe[3:1])
            `CHK("wait_in", 1'b0, bus_wait_n)
            axi_wr(`BCG_IDX_WAIT, 32'h0000_00ff, r);
            axi_wr(`BCG_IDX_DIR, 32'h1, r);
            ext_oe <= 4'h0;
            repeat (4) @(posedge mclk);
            `CHK("pin0_gpio", 2'b11, ({pin_oe[0], bus_wait_n}))
            axi_wr(`BCG_IDX_DIR, 32'h0, r);
            ext_oe <= 4'h1;
            axi_wr(`BCG_IDX_WAIT, 32'h0000_01ff, r);
            repeat (4) @(posedge mclk);
            `CHK("wait_mode", 2'b00, ({pin_oe[0], bus_wait_n}))
        end
        axi_wr(`BCG_IDX_CTRL, 32'h7, r);
        axi_wr(`BCG_IDX_DIR, 32'hff, r);
        hw_standby_n <= 1'b0;
        ext_oe <= 4'hf;
        repeat (8) @(posedge mclk);
        `CHK("hw_oe", 4'h0, pin_oe)
        hw_standby_n <= 1'b1;
        repeat (4) @(posedge mclk);
        axi_rd(`BCG_IDX_LATCH, d, r);
        `CHK("hw_latch", exp_lat(8'h80, 8'h80, ext_val), d[7:0])
        wrap_up();
    end
endmodule // tb_bcg_port
`default_nettype wire
